// File: logic/apll_defines.svh
`ifndef APLL_DEFINES_SVH
`define APLL_DEFINES_SVH
// Register offsets (byte addresses on the plain port)
`define APLL_SOFT_RESET_ADDR 8'h00
`define APLL_DLL_CTRL_ADDR 8'h52
`define APLL_CLK_SOURCE_ADDR 8'h53
`define APLL_REFDIV_LO_ADDR 8'h54
`define APLL_REFDIV_HI_ADDR 8'h55
`define APLL_FBDIV_LO_ADDR 8'h56
`define APLL_FBDIV_HI_ADDR 8'h57
`define APLL_CP_ADDR 8'h58
`define APLL_MASTER_EN_ADDR 8'h59
`define APLL_RES_ADDR 8'h5a
`define APLL_CAP3_ADDR 8'h5b
`define APLL_CAP1_ADDR 8'h5c
`define APLL_CAP2_ADDR 8'h5d
`define APLL_BIAS_OUT_ADDR 8'h5f
`define APLL_CAL_TRIG_ADDR 8'h6b
`define APLL_DLY_EN_ADDR 8'h6d
`define APLL_STATUS_ADDR 8'hd1
// Field positions
`define APLL_DLL_RESET_BIT 0
`define APLL_DLL_ENABLE_BIT 1
`define APLL_CLK_SOURCE_BIT 0
`define APLL_PLL_EN_BIT 0
`define APLL_REFDIV_EN_BIT 1
`define APLL_BIAS_EN_BIT 0
`define APLL_OUT_EN_BIT 1
`define APLL_PLL_CLK_EN_BIT 3
`define APLL_CAL_BUSY_BIT 0
`define APLL_VCOL_BIT 1
`define APLL_VCOH_BIT 2
// Reset values
`define APLL_DLL_CTRL_RESET 8'h01
`define APLL_REFDIV_RESET 10'h001
`define APLL_FBDIV_RESET 12'h001
`define APLL_OUTDIV_RESET 4'h1
`define APLL_CP_RESET 4'h4
`define APLL_FILTER_RESET 5'h1f
// Timing
`define APLL_CAL_TIME_US 50
`define APLL_CLK_MHZ 40
`define APLL_CAL_CYCLES (`APLL_CAL_TIME_US * `APLL_CLK_MHZ)
`define APLL_SRST_CYCLES 16
`endif

// File: logic/apll_pkg.sv
package apll_pkg;
   typedef enum logic [2:0] {
      APLL_IDLE = 3'b001,
      APLL_SRST = 3'b010,
      APLL_CAL = 3'b100
   } apll_state_type;
endpackage

// File: logic/apll_ctrl.sv
// Contract
// (R01) Host resets delay loop by its control bit when clock stops or changes.
// (R02) Delay loop stays in reset while its reset control bit is set.
// (R03) Soft reset with delay loop enabled resets it, then clears reset bit.
// (R04) Clock source bit one selects PLL output as core sampling clock.
// (R05) Host uses PLL mode for 80-250 MHz sampling, 5-250 MHz reference.
// (R06) Reference divider R is a 10-bit field, values 1 to 1023.
// (R07) Feedback prescaler N is a 12-bit field, values 1 to 4095.
// (R08) Host keeps VCO frequency between 1.075 and 1.325 GHz.
// (R09) Host keeps comparison frequency between 4 and 50 MHz.
// (R10) Sampling clock is VCO divided by 4-bit output divider.
// (R11) Charge-pump current is a 4-bit code, 25 uA per step.
// (R12) Host prefers low VCO and high comparison frequency for jitter.
// (R13) Host recalibrates after reference or divider register changes.
// (R14) Calibration starts on trigger toggle or on soft reset exit.
// (R15) Calibration progress is readable in the status register.
// (R16) Low and high VCO drift flags are readable in the status register.
// (R17) 3-bit field delays output data clock in VCO cycles.
// (R18) PLL clock enable bit routes PLL output to converter circuits.
// (R19) Separate enables for PLL, reference divider, bias and output.
// (R20) 5-bit loop filter resistor and three capacitor codes.
// (R21) Clock source zero feeds external clock to delay loop and sampling.
// (R22) Trigger is a rising edge; busy holds until calibration done.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "apll_defines.svh"
module apll_ctrl (
   // Clock, enable, reset
   input wire logic clk_sys,
   input wire logic clk_en,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Analog loop monitors
   input wire logic vco_low_drift_in,
   input wire logic vco_high_drift_in,
   // Clock path controls
   output logic dll_reset,
   output logic dll_enable,
   output logic sample_clk_from_pll,
   output logic pll_clk_to_core,
   output logic pll_enable,
   output logic ref_divider_enable,
   output logic pll_bias_enable,
   output logic pll_output_enable,
   output logic [9:0] ref_divider_r,
   output logic [11:0] feedback_divider_n,
   output logic [3:0] output_divider,
   output logic [3:0] charge_pump_current_code,
   output logic [4:0] loop_filter_resistor_code,
   output logic [4:0] loop_filter_cap_one_code,
   output logic [4:0] loop_filter_cap_two_code,
   output logic [4:0] loop_filter_cap_three_code,
   output logic [2:0] output_clock_vco_delay,
   output logic pll_cal_start,
   output logic core_soft_reset
);
   logic [7:0] delay_loop_control, next_delay_loop_control;
   logic clk_source, next_clk_source;
   logic [9:0] next_ref_divider_r;
   logic [11:0] next_feedback_divider_n;
   logic [3:0] next_output_divider, next_charge_pump_current_code;
   logic [4:0] next_res, next_cap1, next_cap2, next_cap3;
   logic [1:0] master_en, next_master_en;
   logic [1:0] bias_out_en, next_bias_out_en;
   logic cal_trigger_bit, next_cal_trigger_bit;
   logic [2:0] next_delay;
   logic pll_clk_en, next_pll_clk_en;
   apll_pkg::apll_state_type state, next_state;
   logic [15:0] count, next_count;
   logic dll_was_on, next_dll_was_on;
   logic vcol, vcoh, next_vcol, next_vcoh;
   logic [7:0] next_reg_rdata;
   logic next_cal_start;
   logic cal_rise;

   always_comb begin
      next_delay_loop_control = delay_loop_control;
      next_clk_source = clk_source;
      next_ref_divider_r = ref_divider_r;
      next_feedback_divider_n = feedback_divider_n;
      next_output_divider = output_divider;
      next_charge_pump_current_code = charge_pump_current_code;
      next_res = loop_filter_resistor_code;
      next_cap1 = loop_filter_cap_one_code;
      next_cap2 = loop_filter_cap_two_code;
      next_cap3 = loop_filter_cap_three_code;
      next_master_en = master_en;
      next_bias_out_en = bias_out_en;
      next_cal_trigger_bit = cal_trigger_bit;
      next_delay = output_clock_vco_delay;
      next_pll_clk_en = pll_clk_en;
      cal_rise = 1'b0;
      if (reg_wr) begin
         unique case (reg_addr)
            `APLL_DLL_CTRL_ADDR: next_delay_loop_control = reg_wdata;
            `APLL_CLK_SOURCE_ADDR: next_clk_source = reg_wdata[`APLL_CLK_SOURCE_BIT];
            `APLL_REFDIV_LO_ADDR: next_ref_divider_r[7:0] = reg_wdata; // (R06)
            `APLL_REFDIV_HI_ADDR: begin
               next_ref_divider_r[9:8] = reg_wdata[1:0]; // (R06)
               next_output_divider = reg_wdata[7:4]; // (R10)
            end
            `APLL_FBDIV_LO_ADDR: next_feedback_divider_n[7:0] = reg_wdata; // (R07)
            `APLL_FBDIV_HI_ADDR: next_feedback_divider_n[11:8] = reg_wdata[3:0]; // (R07)
            `APLL_CP_ADDR: next_charge_pump_current_code = reg_wdata[3:0]; // (R11)
            `APLL_MASTER_EN_ADDR: next_master_en = reg_wdata[1:0]; // (R19)
            `APLL_RES_ADDR: next_res = reg_wdata[4:0]; // (R20)
            `APLL_CAP3_ADDR: next_cap3 = reg_wdata[4:0]; // (R20)
            `APLL_CAP1_ADDR: next_cap1 = reg_wdata[4:0]; // (R20)
            `APLL_CAP2_ADDR: next_cap2 = reg_wdata[4:0]; // (R20)
            `APLL_BIAS_OUT_ADDR: next_bias_out_en = reg_wdata[1:0]; // (R19)
            `APLL_CAL_TRIG_ADDR: begin
               next_cal_trigger_bit = reg_wdata[0];
               cal_rise = reg_wdata[0] & ~cal_trigger_bit; // (R22)
            end
            `APLL_DLY_EN_ADDR: begin
               next_delay = reg_wdata[2:0]; // (R17)
               next_pll_clk_en = reg_wdata[`APLL_PLL_CLK_EN_BIT]; // (R18)
            end
            default: ;
         endcase
      end
      // Auto-clear after soft reset beats a host write in the same cycle
      if (state == apll_pkg::APLL_SRST && count == 16'h0000 && dll_was_on) begin
         next_delay_loop_control[`APLL_DLL_RESET_BIT] = 1'b0; // (R03)
      end
   end

   always_comb begin
      next_state = state;
      next_count = count;
      next_dll_was_on = dll_was_on;
      next_cal_start = 1'b0;
      unique case (state)
         apll_pkg::APLL_IDLE: begin
            if (cal_rise) begin
               next_state = apll_pkg::APLL_CAL; // (R14)
               next_count = 16'(`APLL_CAL_CYCLES - 1);
               next_cal_start = 1'b1;
            end
         end
         apll_pkg::APLL_SRST: begin
            if (count == 16'h0000) begin
               next_state = apll_pkg::APLL_CAL; // (R14)
               next_count = 16'(`APLL_CAL_CYCLES - 1);
               next_cal_start = 1'b1;
            end else begin
               next_count = count - 16'h0001;
            end
         end
         apll_pkg::APLL_CAL: begin
            // Further triggers while busy are ignored; the run in progress covers them
            if (count == 16'h0000) begin
               next_state = apll_pkg::APLL_IDLE; // (R22)
            end else begin
               next_count = count - 16'h0001;
            end
         end
      endcase
      // A soft reset is honoured in any state, so it also restarts a calibration in progress
      if (reg_wr && reg_addr == `APLL_SOFT_RESET_ADDR) begin
         next_state = apll_pkg::APLL_SRST; // (R03)
         next_count = 16'(`APLL_SRST_CYCLES - 1);
         next_dll_was_on = delay_loop_control[`APLL_DLL_ENABLE_BIT];
         next_cal_start = 1'b0;
      end
   end

   always_comb begin
      next_vcol = vco_low_drift_in; // (R16)
      next_vcoh = vco_high_drift_in; // (R16)
      next_reg_rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `APLL_DLL_CTRL_ADDR: next_reg_rdata = delay_loop_control;
            `APLL_CLK_SOURCE_ADDR: next_reg_rdata = {7'h00, clk_source};
            `APLL_REFDIV_LO_ADDR: next_reg_rdata = ref_divider_r[7:0];
            `APLL_REFDIV_HI_ADDR: next_reg_rdata = {output_divider, 2'h0, ref_divider_r[9:8]};
            `APLL_FBDIV_LO_ADDR: next_reg_rdata = feedback_divider_n[7:0];
            `APLL_FBDIV_HI_ADDR: next_reg_rdata = {4'h0, feedback_divider_n[11:8]};
            `APLL_CP_ADDR: next_reg_rdata = {4'h0, charge_pump_current_code};
            `APLL_MASTER_EN_ADDR: next_reg_rdata = {6'h00, master_en};
            `APLL_RES_ADDR: next_reg_rdata = {3'h0, loop_filter_resistor_code};
            `APLL_CAP3_ADDR: next_reg_rdata = {3'h0, loop_filter_cap_three_code};
            `APLL_CAP1_ADDR: next_reg_rdata = {3'h0, loop_filter_cap_one_code};
            `APLL_CAP2_ADDR: next_reg_rdata = {3'h0, loop_filter_cap_two_code};
            `APLL_BIAS_OUT_ADDR: next_reg_rdata = {6'h00, bias_out_en};
            `APLL_CAL_TRIG_ADDR: next_reg_rdata = {7'h00, cal_trigger_bit};
            `APLL_DLY_EN_ADDR: next_reg_rdata = {4'h0, pll_clk_en, output_clock_vco_delay};
            `APLL_STATUS_ADDR: begin
               next_reg_rdata[`APLL_CAL_BUSY_BIT] = (state != apll_pkg::APLL_IDLE); // (R15)
               next_reg_rdata[`APLL_VCOL_BIT] = vcol; // (R16)
               next_reg_rdata[`APLL_VCOH_BIT] = vcoh; // (R16)
            end
            default: next_reg_rdata = 8'h00;
         endcase
      end
   end

   // The host cannot write during the reset, so the loop stays held until it clears the bit
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         delay_loop_control <= `APLL_DLL_CTRL_RESET; // (R02)
         clk_source <= 1'b0;
         ref_divider_r <= `APLL_REFDIV_RESET;
         feedback_divider_n <= `APLL_FBDIV_RESET;
         output_divider <= `APLL_OUTDIV_RESET;
         charge_pump_current_code <= `APLL_CP_RESET;
         loop_filter_resistor_code <= `APLL_FILTER_RESET;
         loop_filter_cap_one_code <= `APLL_FILTER_RESET;
         loop_filter_cap_two_code <= `APLL_FILTER_RESET;
         loop_filter_cap_three_code <= `APLL_FILTER_RESET;
         master_en <= 2'h0;
         bias_out_en <= 2'h0;
         cal_trigger_bit <= 1'b0;
         output_clock_vco_delay <= 3'h0;
         pll_clk_en <= 1'b0;
         state <= apll_pkg::APLL_IDLE;
         count <= 16'h0000;
         dll_was_on <= 1'b0;
         vcol <= 1'b0;
         vcoh <= 1'b0;
         reg_rdata <= 8'h00;
         pll_cal_start <= 1'b0;
         dll_reset <= 1'b1;
         dll_enable <= 1'b0;
         sample_clk_from_pll <= 1'b0;
         pll_clk_to_core <= 1'b0;
         pll_enable <= 1'b0;
         ref_divider_enable <= 1'b0;
         pll_bias_enable <= 1'b0;
         pll_output_enable <= 1'b0;
         core_soft_reset <= 1'b0;
      end else if (clk_en) begin
         delay_loop_control <= next_delay_loop_control;
         clk_source <= next_clk_source;
         ref_divider_r <= next_ref_divider_r;
         feedback_divider_n <= next_feedback_divider_n;
         output_divider <= next_output_divider;
         charge_pump_current_code <= next_charge_pump_current_code;
         loop_filter_resistor_code <= next_res;
         loop_filter_cap_one_code <= next_cap1;
         loop_filter_cap_two_code <= next_cap2;
         loop_filter_cap_three_code <= next_cap3;
         master_en <= next_master_en;
         bias_out_en <= next_bias_out_en;
         cal_trigger_bit <= next_cal_trigger_bit;
         output_clock_vco_delay <= next_delay;
         pll_clk_en <= next_pll_clk_en;
         state <= next_state;
         count <= next_count;
         dll_was_on <= next_dll_was_on;
         vcol <= next_vcol;
         vcoh <= next_vcoh;
         reg_rdata <= next_reg_rdata;
         pll_cal_start <= next_cal_start; // (R14)
         // Loop also held through a soft reset taken while it was enabled
         dll_reset <= next_delay_loop_control[`APLL_DLL_RESET_BIT]
            | (next_state == apll_pkg::APLL_SRST && next_dll_was_on); // (R02) (R03)
         dll_enable <= next_delay_loop_control[`APLL_DLL_ENABLE_BIT];
         sample_clk_from_pll <= next_clk_source; // (R04) (R21)
         pll_clk_to_core <= next_pll_clk_en; // (R18)
         pll_enable <= next_master_en[`APLL_PLL_EN_BIT]; // (R19)
         ref_divider_enable <= next_master_en[`APLL_REFDIV_EN_BIT]; // (R19)
         pll_bias_enable <= next_bias_out_en[`APLL_BIAS_EN_BIT]; // (R19)
         pll_output_enable <= next_bias_out_en[`APLL_OUT_EN_BIT]; // (R19)
         core_soft_reset <= (next_state == apll_pkg::APLL_SRST); // (R03)
      end
   end
endmodule

// File: test/apll_ctrl_chk.sv
`timescale 1ns/1ps
module apll_ctrl_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic clk_en,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Monitors and controls
   input wire logic vco_low_drift_in,
   input wire logic vco_high_drift_in,
   input wire logic dll_reset,
   input wire logic dll_enable,
   input wire logic sample_clk_from_pll,
   input wire logic pll_clk_to_core,
   input wire logic [9:0] ref_divider_r,
   input wire logic [11:0] feedback_divider_n,
   input wire logic [3:0] output_divider,
   input wire logic [3:0] charge_pump_current_code,
   input wire logic [2:0] output_clock_vco_delay,
   input wire logic pll_cal_start,
   input wire logic core_soft_reset
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Frozen cycles are skipped, so only taken writes qualify
   wire w = reg_wr && clk_en;
   property p_dll_hold;
      w && reg_addr == 8'h52 && reg_wdata[0] && !core_soft_reset |=> dll_reset;
   endproperty
   a_dll_hold: assert property (p_dll_hold) else $error("delay loop not held");
   property p_dll_en;
      w && reg_addr == 8'h52 |=> dll_enable == $past(reg_wdata[1]);
   endproperty
   a_dll_en: assert property (p_dll_en) else $error("delay loop enable wrong");
   property p_src;
      w && reg_addr == 8'h53 |=> sample_clk_from_pll == $past(reg_wdata[0]);
   endproperty
   a_src: assert property (p_src) else $error("clock source wrong");
   property p_refdiv;
      w && reg_addr == 8'h54 |=> ref_divider_r[7:0] == $past(reg_wdata);
   endproperty
   a_refdiv: assert property (p_refdiv) else $error("ref divider wrong");
   property p_fbdiv;
      w && reg_addr == 8'h57 |=> feedback_divider_n[11:8] == $past(reg_wdata[3:0]);
   endproperty
   a_fbdiv: assert property (p_fbdiv) else $error("feedback divider wrong");
   property p_outdiv;
      w && reg_addr == 8'h55 |=> output_divider == $past(reg_wdata[7:4]);
   endproperty
   a_outdiv: assert property (p_outdiv) else $error("output divider wrong");
   property p_cp;
      w && reg_addr == 8'h58 |=> charge_pump_current_code == $past(reg_wdata[3:0]);
   endproperty
   a_cp: assert property (p_cp) else $error("charge pump code wrong");
   property p_dly;
      w && reg_addr == 8'h6d |=> {pll_clk_to_core, output_clock_vco_delay} == $past(reg_wdata[3:0]);
   endproperty
   a_dly: assert property (p_dly) else $error("clock delay or enable wrong");
   property p_srst;
      w && reg_addr == 8'h00 && !core_soft_reset |=> core_soft_reset [*8];
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset too short");
   property p_cal;
      $fell(core_soft_reset) |-> ##[0:2] pll_cal_start;
   endproperty
   a_cal: assert property (p_cal) else $error("no calibration after soft reset");
   property p_pulse;
      pll_cal_start |=> !pll_cal_start;
   endproperty
   a_pulse: assert property (p_pulse) else $error("start pulse too long");
   property p_rd_idle;
      $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_drift;
      reg_rd && clk_en && reg_addr == 8'hd1 |=>
         reg_rdata[2:1] == $past({vco_high_drift_in, vco_low_drift_in}, 2);
   endproperty
   a_drift: assert property (p_drift) else $error("drift flags wrong");
   c_srst: cover property (core_soft_reset ##1 !core_soft_reset);
   c_cal: cover property (pll_cal_start);
   c_drift: cover property (reg_rd && reg_addr == 8'hd1);
endmodule
bind apll_ctrl apll_ctrl_chk i_chk (.*);

// File: test/adc_sample_clock_pll_dll_control_test.sv
`timescale 1ns/1ps
module adc_sample_clock_pll_dll_control_test;
   logic clk_sys, clk_en, rst, reg_wr, reg_rd, vco_low_drift_in, vco_high_drift_in;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic dll_reset, dll_enable, sample_clk_from_pll, pll_clk_to_core, pll_enable;
   logic ref_divider_enable, pll_bias_enable, pll_output_enable, pll_cal_start, core_soft_reset;
   logic [9:0] ref_divider_r;
   logic [11:0] feedback_divider_n;
   logic [3:0] output_divider, charge_pump_current_code;
   logic [4:0] loop_filter_resistor_code, loop_filter_cap_one_code;
   logic [4:0] loop_filter_cap_two_code, loop_filter_cap_three_code;
   logic [2:0] output_clock_vco_delay;
   logic [15:0] tbl [13];
   int err_count = 0;
   int tests_run = 0;
   int n;
   apll_ctrl i_dut (.*);
   initial begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 0;
      #1;
   endtask
   // Read data only stands in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_start();
      n = 0;
      while (!pll_cal_start && n < 4) begin
         @(posedge clk_sys);
         #1 n++;
      end
   endtask
   task automatic t_reset();
      chk({dll_reset, dll_enable, sample_clk_from_pll, pll_clk_to_core}, 4'h8);
      chk({ref_divider_r, feedback_divider_n}, {10'h001, 12'h001});
      chk({output_divider, charge_pump_current_code}, 8'h14);
      chk({loop_filter_resistor_code, loop_filter_cap_three_code, loop_filter_cap_one_code,
           loop_filter_cap_two_code}, 20'hfffff);
      rd(8'h52);
      chk(d, 8'h01);
      wr(8'h52, 8'h00);
      chk(dll_reset, 1'b0);
      $display("reset test done");
   endtask
   task automatic t_fields();
      // R=10, N=120, divide by 6: legal loop for a 100 MHz reference
      tbl = '{16'h5301, 16'h540a, 16'h5560, 16'h5678, 16'h5700, 16'h580f, 16'h5903,
              16'h5a07, 16'h5b02, 16'h5c08, 16'h5d01, 16'h5f03, 16'h6d0f};
      foreach (tbl[i]) wr(tbl[i][15:8], tbl[i][7:0]);
      chk(sample_clk_from_pll, 1'b1);
      chk({ref_divider_r, feedback_divider_n}, {10'h00a, 12'h078});
      chk({output_divider, charge_pump_current_code}, 8'h6f);
      chk({pll_enable, ref_divider_enable, pll_bias_enable, pll_output_enable}, 4'hf);
      chk({loop_filter_resistor_code, loop_filter_cap_three_code, loop_filter_cap_one_code,
           loop_filter_cap_two_code}, {5'h07, 5'h02, 5'h08, 5'h01});
      chk({pll_clk_to_core, output_clock_vco_delay}, 4'hf);
      wr(8'h53, 8'h00);
      chk(sample_clk_from_pll, 1'b0);
      rd(8'h60);
      chk(d, 8'h00);
      // Frozen clock enable: a write must not land
      @(posedge clk_sys);
      clk_en <= 0;
      wr(8'h58, 8'h03);
      @(posedge clk_sys);
      clk_en <= 1;
      #1 chk(charge_pump_current_code, 4'hf);
      $display("field test done");
   endtask
   task automatic t_cal();
      vco_low_drift_in <= 1;
      wr(8'h6b, 8'h01);
      wait_start();
      chk(pll_cal_start, 1'b1);
      rd(8'hd1);
      chk(d[2:0], 3'b011);
      wr(8'h6b, 8'h00);
      wr(8'h6b, 8'h01);
      n = 0;
      repeat (4) begin
         @(posedge clk_sys);
         #1 n += pll_cal_start;
      end
      chk(n, 0);
      repeat (1900) @(posedge clk_sys);
      rd(8'hd1);
      chk(d[0], 1'b1);
      repeat (120) @(posedge clk_sys);
      rd(8'hd1);
      chk(d[0], 1'b0);
      $display("calibration test done");
   endtask
   task automatic t_srst();
      vco_low_drift_in <= 0;
      vco_high_drift_in <= 1;
      wr(8'h52, 8'h03);
      wr(8'h00, 8'h00);
      n = 0;
      while (core_soft_reset && n < 40) begin
         chk(dll_reset, 1'b1);
         @(posedge clk_sys);
         #1 n++;
      end
      chk(n, 16);
      wait_start();
      chk(pll_cal_start, 1'b1);
      chk({dll_reset, dll_enable}, 2'b01);
      rd(8'h52);
      chk(d[1:0], 2'b10);
      repeat (2050) @(posedge clk_sys);
      rd(8'hd1);
      chk(d[2:0], 3'b100);
      $display("soft reset test done");
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Whole run needs about 4200 cycles
   initial begin
      repeat (10000) @(posedge clk_sys);
      err_count++;
      $display("watchdog expired");
      print_verdict();
   end
   initial begin
      clk_en = 1;
      rst = 1;
      reg_wr = 0;
      reg_rd = 0;
      reg_addr = 0;
      reg_wdata = 0;
      vco_low_drift_in = 0;
      vco_high_drift_in = 0;
      repeat (3) @(posedge clk_sys);
      rst <= 0;
      @(posedge clk_sys);
      #1 t_reset();
      t_fields();
      t_cal();
      t_srst();
      print_verdict();
   end
endmodule
